// ===== dv/ior_host_model.sv
`timescale 1ns/1ps
module ior_host_model (
   input wire logic clk_sys,
   input wire logic miso_out,
   input wire logic miso_oe,
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   output logic [15:0] rx,
   output logic done
);
   logic last_miso = 1'b0;
   logic miso_w;
   // a released line shows the inverse of its last level, never a held value
   always @(posedge clk_sys) begin
      if (miso_oe === 1'b1) last_miso <= miso_out;
   end
   assign miso_w = (miso_oe === 1'b1) ? miso_out : ~last_miso;
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
      rx = 16'h0000;
      done = 1'b0;
   end
   // mode 3, msb first; half period of 10 clocks keeps well inside the sync margin
   task automatic frame(input logic [15:0] cmd, input int n);
      cs_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         mosi = (i < 16) ? cmd[15 - i] : 1'b0;
         repeat (10) @(negedge clk_sys);
         sclk = 1'b1;
         rx = {rx[14:0], miso_w};
         repeat (10) @(negedge clk_sys);
      end
      cs_n = 1'b1;
      mosi = ~mosi;
      repeat (10) @(negedge clk_sys);
      done = (n == 16);
      @(negedge clk_sys);
      done = 1'b0;
   endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   import ior_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic sample_strobe = 1'b0;
   logic [31:0] smp [4];
   logic [31:0] bnd [4] = '{32'h4e200000, 32'hb1e00000, 32'h7d000000, 32'h83000000};
   logic sclk, cs_n, mosi, miso_out, miso_oe, done;
   ior_word_t rx;
   logic [16:0] pend;
   logic [16:0] e;
   logic [16:0] exp_q [$];
   int fail_count = 0;
   int comparisons = 0;
   always #2.5 clk_sys = ~clk_sys;
   ior_output_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .sample_strobe(sample_strobe),
      .rate_x_sample(smp[0]), .rate_y_sample(smp[1]), .rate_z_sample(smp[2]),
      .accel_x_sample(smp[3]), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso_out(miso_out), .spi_miso_oe(miso_oe));
   ior_host_model host (.clk_sys(clk_sys), .miso_out(miso_out), .miso_oe(miso_oe),
      .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .rx(rx), .done(done));
   // bit 16 set means the reply is not checked
   function automatic logic [16:0] word_of(input logic [6:0] a);
      if (a < 7'h04 || a > 7'h13) return 17'h00000;
      return {1'b0, a[1] ? smp[(a - 7'h04) >> 2][31:16] : smp[(a - 7'h04) >> 2][15:0]};
   endfunction
   // each frame carries the reply to the previous read command
   task automatic xfer(input logic [6:0] a, input logic wr, input int n);
      if (n == 16) exp_q.push_back(pend);
      host.frame({wr, a, 8'($urandom)}, n);
      if (n == 16 && !wr) pend = word_of(a);
   endtask
   task automatic report_and_stop;
      if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      if (done === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[16] === 1'b0) begin
            comparisons++;
            if (rx !== e[15:0]) begin
               $display("unexpected at %0t: got %h want %h", $time, rx, e[15:0]);
               fail_count++;
            end
         end
      end
   end
   initial begin
      void'($urandom(78));
      pend = {1'b0, IOR_UNMAPPED_DATA};
      for (int k = 0; k < 4; k++) smp[k] = 32'h0;
      repeat (6) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (4) @(negedge clk_sys);
      xfer(7'h04, 1'b0, 16);
      xfer(7'h12, 1'b0, 16);
      for (int r = 0; r < 3; r++) begin
         // back-to-back strobes: only the second sample may survive
         for (int k = 0; k < 4; k++) smp[k] = $urandom;
         sample_strobe = 1'b1;
         @(negedge clk_sys);
         for (int k = 0; k < 4; k++) smp[k] = (r == 0) ? bnd[k] : $urandom;
         @(negedge clk_sys);
         sample_strobe = 1'b0;
         for (int a = 2; a < 22; a++) xfer(7'(a), 1'b0, 16);
      end
      xfer(7'h0e, 1'b0, 16);
      // write and bad-length frames must leave the pending reply and the words alone
      xfer(7'h06, 1'b1, 16);
      xfer(7'h06, 1'b0, 15);
      xfer(7'h0a, 1'b0, 17);
      xfer(7'h06, 1'b0, 16);
      xfer(7'h00, 1'b0, 16);
      // mid-run reset: words and pending reply fall back to zero
      resetn = 1'b0;
      repeat (3) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (4) @(negedge clk_sys);
      pend = {1'b0, IOR_UNMAPPED_DATA};
      xfer(7'h12, 1'b0, 16);
      pend = {1'b0, IOR_WORD_RESET};
      xfer(7'h00, 1'b0, 16);
      report_and_stop;
   end
   initial begin
      #400000;
      fail_count++;
      report_and_stop;
   end
endmodule

// ===== logic/ior_output_regs.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] rate high word: 16-bit twos complement, zero is 0x0000, step 0.1 deg/s.
// [R2] each rate axis has a 16-bit low word of extra fractional resolution.
// [R3] high and low rate words form one 32-bit value, high word upper.
// [R4] x rate low word at 0x04/0x05, high word at 0x06/0x07.
// [R5] y rate low word at 0x08/0x09, high word at 0x0a/0x0b.
// [R6] z rate low word at 0x0c/0x0d, high word at 0x0e/0x0f.
// [R7] acceleration includes motion and gravity, on the rate axes.
// [R8] acceleration words concatenate high first into one 32-bit value.
// [R9] x acceleration low word, 16 extra resolution bits, at 0x10/0x11.
// [R10] acceleration high word: twos complement, +-40 g, step 1.25 mg.
// [R11] output words are read-only; writes change nothing and have no effect.
// [R12] high and low words of an axis update together from one sample.
module ior_output_regs
   import ior_pkg::*;
#(
   parameter int NUM_WORDS = IOR_NUM_WORDS
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sample_strobe,
   input wire logic [31:0] rate_x_sample,
   input wire logic [31:0] rate_y_sample,
   input wire logic [31:0] rate_z_sample,
   input wire logic [31:0] accel_x_sample,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso_out,
   output logic spi_miso_oe
);
   logic [IOR_WORD_W*NUM_WORDS-1:0] sample_bus;
   ior_word_t out_word [NUM_WORDS];
   ior_word_t tx_hold;
   ior_word_t rx_word;
   logic frame_done;
   logic cmd_read;
   logic [IOR_ADDR_W-1:0] cmd_addr;
   logic [3:0] slot;
   ior_word_t rate_x_fraction;
   ior_word_t rate_x_word;
   ior_word_t rate_y_fraction;
   ior_word_t rate_y_word;
   ior_word_t rate_z_fraction;
   ior_word_t rate_z_word;
   ior_word_t accel_x_fraction;
   ior_word_t accel_x_word;

   // returns {hit, index}; the odd byte of a pair reads the same word
   function automatic logic [3:0] addr_to_slot(input logic [IOR_ADDR_W-1:0] a);
      logic [5:0] diff;
      diff = a[6:1] - IOR_RATE_X_FRACTION_ADDR[6:1];
      addr_to_slot = {(a[6:1] >= IOR_RATE_X_FRACTION_ADDR[6:1]) &&
                      (diff < 6'(NUM_WORDS)), diff[2:0]};
   endfunction

   // lower word index holds the fraction, so each axis sits high word above low
   assign sample_bus = {accel_x_sample, rate_z_sample, rate_y_sample, rate_x_sample}; // [R3] [R8]

   genvar gi;
   generate
      for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
         // whole sample captured in one edge keeps both halves coherent
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               out_word[gi] <= IOR_WORD_RESET;
            end else if (sample_strobe) begin
               out_word[gi] <= sample_bus[IOR_WORD_W*gi +: IOR_WORD_W]; // [R12] [R1] [R2] [R7] [R10]
            end
         end
      end
   endgenerate

   assign rate_x_fraction = out_word[0];
   assign rate_x_word = out_word[1];
   assign rate_y_fraction = out_word[2];
   assign rate_y_word = out_word[3];
   assign rate_z_fraction = out_word[4];
   assign rate_z_word = out_word[5];
   assign accel_x_fraction = out_word[6];
   assign accel_x_word = out_word[7];

   ior_spi_frame #(
      .FRAME_BITS(IOR_FRAME_BITS)
   ) u_frame (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .sclk_pin(spi_sclk),
      .cs_n_pin(spi_cs_n),
      .mosi_pin(spi_mosi),
      .tx_word(tx_hold),
      .frame_done(frame_done),
      .rx_word(rx_word),
      .miso_out(spi_miso_out),
      .miso_oe(spi_miso_oe)
   );

   assign cmd_read = (rx_word[IOR_RW_BIT] == IOR_CMD_READ);
   assign cmd_addr = rx_word[IOR_ADDR_LSB +: IOR_ADDR_W];
   assign slot = addr_to_slot(cmd_addr);

   // reply is frozen at command time and shifted out in the next frame;
   // write frames fall through untouched
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_hold <= IOR_UNMAPPED_DATA;
      end else if (frame_done && cmd_read) begin
         tx_hold <= slot[3] ? out_word[slot[2:0]] : IOR_UNMAPPED_DATA; // [R4] [R5] [R6] [R9] [R11]
      end
   end

   property p_rate_x_split;
      @(posedge clk_sys) disable iff (!resetn)
      sample_strobe |=> ({rate_x_word, rate_x_fraction} == $past(rate_x_sample));
   endproperty
   a_rate_x_split: assert property (p_rate_x_split) else $error("x rate words not split from sample"); // [R1] [R2] [R3]

   property p_accel_split;
      @(posedge clk_sys) disable iff (!resetn)
      sample_strobe |=> (accel_x_word == $past(accel_x_sample[31:16])) &&
                        (accel_x_fraction == $past(accel_x_sample[15:0]));
   endproperty
   a_accel_split: assert property (p_accel_split) else $error("x accel words not split from sample"); // [R7] [R8] [R10]

   property p_hold;
      @(posedge clk_sys) disable iff (!resetn)
      !sample_strobe |=> $stable(rate_y_word) && $stable(rate_y_fraction) &&
                         $stable(rate_z_word) && $stable(rate_z_fraction);
   endproperty
   a_hold: assert property (p_hold) else $error("output word changed without a sample"); // [R12]

   property p_write_ignored;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && !cmd_read && !sample_strobe) |=> $stable(rate_x_word) &&
         $stable(accel_x_fraction) && $stable(tx_hold);
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write frame had an effect"); // [R11]

   property p_map_x;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && cmd_addr == IOR_RATE_X_WORD_ADDR) |=>
         (tx_hold == $past(rate_x_word));
   endproperty
   a_map_x: assert property (p_map_x) else $error("x rate high word reply wrong"); // [R4]

   property p_map_y;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && cmd_addr == IOR_RATE_Y_FRACTION_ADDR) |=>
         (tx_hold == $past(rate_y_fraction));
   endproperty
   a_map_y: assert property (p_map_y) else $error("y rate low word reply wrong"); // [R5]

   property p_map_z;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && cmd_addr == IOR_RATE_Z_WORD_ADDR) |=>
         (tx_hold == $past(rate_z_word));
   endproperty
   a_map_z: assert property (p_map_z) else $error("z rate high word reply wrong"); // [R6]

   property p_map_accel;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && cmd_addr == IOR_ACCEL_X_FRACTION_ADDR) |=>
         (tx_hold == $past(accel_x_fraction));
   endproperty
   a_map_accel: assert property (p_map_accel) else $error("x accel low word reply wrong"); // [R9]

   property p_map_x_odd;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && cmd_addr == {IOR_RATE_X_WORD_ADDR[6:1], 1'b1}) |=>
         (tx_hold == $past(rate_x_word));
   endproperty
   a_map_x_odd: assert property (p_map_x_odd) else $error("x rate odd byte reply wrong"); // [R4]

   property p_map_y_word;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && cmd_addr == IOR_RATE_Y_WORD_ADDR) |=>
         (tx_hold == $past(rate_y_word));
   endproperty
   a_map_y_word: assert property (p_map_y_word) else $error("y rate high reply wrong"); // [R5]

   property p_map_z_frac;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && cmd_addr == IOR_RATE_Z_FRACTION_ADDR) |=>
         (tx_hold == $past(rate_z_fraction));
   endproperty
   a_map_z_frac: assert property (p_map_z_frac) else $error("z rate low reply wrong"); // [R6]

   property p_map_accel_word;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && cmd_addr == IOR_ACCEL_X_WORD_ADDR) |=>
         (tx_hold == $past(accel_x_word));
   endproperty
   a_map_accel_word: assert property (p_map_accel_word) else $error("x accel high reply wrong"); // [R8]

   property p_rate_yz_split;
      @(posedge clk_sys) disable iff (!resetn)
      sample_strobe |=> ({rate_y_word, rate_y_fraction} == $past(rate_y_sample)) &&
                        ({rate_z_word, rate_z_fraction} == $past(rate_z_sample));
   endproperty
   a_rate_yz_split: assert property (p_rate_yz_split) else $error("y/z rate words not split"); // [R3] [R12]

   property p_hold_x;
      @(posedge clk_sys) disable iff (!resetn)
      !sample_strobe |=> $stable(rate_x_word) && $stable(rate_x_fraction) &&
                         $stable(accel_x_word) && $stable(accel_x_fraction);
   endproperty
   a_hold_x: assert property (p_hold_x) else $error("x word changed without a sample"); // [R12]

   property p_reply_hold;
      @(posedge clk_sys) disable iff (!resetn)
      !frame_done |=> $stable(tx_hold);
   endproperty
   a_reply_hold: assert property (p_reply_hold) else $error("reply changed outside a frame end");

   property p_unmapped;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && !slot[3]) |=> (tx_hold == IOR_UNMAPPED_DATA);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_x_low_addr;
      @(posedge clk_sys) disable iff (!resetn)
      (frame_done && cmd_read && !sample_strobe && cmd_addr == IOR_RATE_X_FRACTION_ADDR) ##1
         (!frame_done && !sample_strobe)[*2] |-> (tx_hold == rate_x_fraction);
   endproperty
   a_x_low_addr: assert property (p_x_low_addr) else $error("x rate low reply not held"); // [R4]
endmodule

// ===== logic/ior_pkg.sv
package ior_pkg;
   localparam int IOR_WORD_W = 16;
   localparam int IOR_NUM_WORDS = 8;
   localparam int IOR_ADDR_W = 7;
   localparam int IOR_SAMPLE_W = 32;

   // byte addresses of the even byte of each word
   localparam logic [6:0] IOR_RATE_X_FRACTION_ADDR = 7'h04;
   localparam logic [6:0] IOR_RATE_X_WORD_ADDR = 7'h06;
   localparam logic [6:0] IOR_RATE_Y_FRACTION_ADDR = 7'h08;
   localparam logic [6:0] IOR_RATE_Y_WORD_ADDR = 7'h0a;
   localparam logic [6:0] IOR_RATE_Z_FRACTION_ADDR = 7'h0c;
   localparam logic [6:0] IOR_RATE_Z_WORD_ADDR = 7'h0e;
   localparam logic [6:0] IOR_ACCEL_X_FRACTION_ADDR = 7'h10;
   localparam logic [6:0] IOR_ACCEL_X_WORD_ADDR = 7'h12;

   localparam logic [15:0] IOR_WORD_RESET = 16'h0000;
   localparam logic [15:0] IOR_UNMAPPED_DATA = 16'h0000;

   // serial frame layout
   localparam int IOR_FRAME_BITS = 16;
   localparam int IOR_RW_BIT = 15;
   localparam int IOR_ADDR_LSB = 8;
   localparam logic IOR_CMD_READ = 1'b0;
   localparam logic IOR_SCLK_IDLE = 1'b1;
   localparam logic IOR_CS_IDLE = 1'b1;

   typedef logic [15:0] ior_word_t;
endpackage

// ===== logic/ior_spi_frame.sv
`timescale 1ns/1ps
module ior_spi_frame
   import ior_pkg::*;
#(
   parameter int FRAME_BITS = IOR_FRAME_BITS
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic mosi_pin,
   input wire ior_word_t tx_word,
   output logic frame_done,
   output ior_word_t rx_word,
   output logic miso_out,
   output logic miso_oe
);
   localparam int CW = $clog2(FRAME_BITS + 2);
   localparam logic [CW-1:0] FULL = CW'(FRAME_BITS);

   logic [1:0] sclk_ff;
   logic [1:0] cs_n_ff;
   logic [1:0] mosi_ff;
   logic sclk_d;
   logic cs_n_d;
   logic [CW-1:0] bit_cnt;
   ior_word_t rx_shift;
   ior_word_t tx_shift;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;

   // pins are asynchronous; sclk must stay well below clk_sys/8
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sclk_ff <= {2{IOR_SCLK_IDLE}};
         cs_n_ff <= {2{IOR_CS_IDLE}};
         mosi_ff <= 2'h0;
         sclk_d <= IOR_SCLK_IDLE;
         cs_n_d <= IOR_CS_IDLE;
      end else begin
         sclk_ff <= {sclk_ff[0], sclk_pin};
         cs_n_ff <= {cs_n_ff[0], cs_n_pin};
         mosi_ff <= {mosi_ff[0], mosi_pin};
         sclk_d <= sclk_ff[1];
         cs_n_d <= cs_n_ff[1];
      end
   end

   assign sclk_rise = sclk_ff[1] & ~sclk_d;
   assign sclk_fall = ~sclk_ff[1] & sclk_d;
   assign cs_fall = ~cs_n_ff[1] & cs_n_d;
   assign cs_rise = cs_n_ff[1] & ~cs_n_d;

   // receive on rising sclk; count saturates one past a full frame so long frames drop
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bit_cnt <= '0;
         rx_shift <= IOR_WORD_RESET;
      end else if (cs_fall) begin
         bit_cnt <= '0;
      end else if (!cs_n_ff[1] && sclk_rise) begin
         rx_shift <= {rx_shift[14:0], mosi_ff[1]};
         if (bit_cnt <= FULL) begin
            bit_cnt <= bit_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         frame_done <= 1'b0;
         rx_word <= IOR_WORD_RESET;
      end else begin
         frame_done <= cs_rise && (bit_cnt == FULL);
         if (cs_rise && (bit_cnt == FULL)) begin
            rx_word <= rx_shift;
         end
      end
   end

   // transmit on falling sclk, msb first
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_shift <= IOR_WORD_RESET;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         miso_oe <= ~cs_n_ff[1];
         if (cs_fall) begin
            tx_shift <= tx_word;
         end else if (!cs_n_ff[1] && sclk_fall) begin
            miso_out <= tx_shift[15];
            tx_shift <= {tx_shift[14:0], 1'b0};
         end
      end
   end
endmodule
